// *** rtl/claim_decode.sv ***
/*
 * Secondary-bus claim decoder and per-cycle response tracker of a two-port
 * bridge. Decides ignore / claim / claim-as-special per address phase and
 * drives the device select and retry of both ports.
 * Assumes address phases are presented synchronous to clk_i, one cycle
 * wide, on the first frame cycle; window settings are held stable.
 */
`timescale 1ns/100ps
`default_nettype none
`include "claim_decode_cfg.svh"

// Functional notes
// - secondary special cycle is never claimed, left unanswered.
// - secondary I/O and memory reads use the inverse of the primary-side window decision.
// - other memory commands decode exactly like memory read.
// - secondary config reads and Type 0 config writes are ignored.
// - secondary Type 1 config write that is no special request: ignore.
// - special request to primary bus is claimed, reissued as special cycle.
// - special request to a foreign bus is forwarded as Type 1 write.
// - special request into secondary..subordinate range is ignored.
// - primary master to primary target: bridge silent, watches select.
// - primary master to downstream target: select, post or retry.
// - after forwarding, wait for the identical repeat, then complete.
// - primary cycle to no target: no answer, master abort follows.
// - secondary cycle to local or unknown target: no answer.
// - secondary cycle going upstream: select, post or retry, forward.
// - primary memory inside forwarded window is claimed, else ignored.
module claim_decode
    import claim_decode_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire window_cfg_t cfg_i,
    input  wire addr_phase_t sec_addr_i,
    input  wire addr_phase_t pri_addr_i,
    input  wire logic        pri_other_devsel_i,
    input  wire logic        postable_i,
    input  wire logic        fwd_done_i,
    output decision_t        sec_dec_o,
    output logic             sec_device_select_n_o,
    output logic             sec_retry_o,
    output logic             primary_device_select_n_o,
    output logic             pri_retry_o,
    output logic             fwd_req_o
);

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'h1,
        ST_FWD  = 3'h2,
        ST_WAIT = 3'h4
    } fwd_state_t;

    typedef struct packed
    {
        decision_t   sdec;
        logic        dac_pend;
        logic        s_sel;
        logic        s_retry;
        logic        p_sel;
        logic        p_retry;
        fwd_state_t  st;
        addr_phase_t held;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic [7:0] s_bus;
    logic       s_in_range;
    logic       s_spc_req;
    logic       s_type1;
    logic       s_mem_in;
    logic       s_io_in;
    logic       p_mem_in;
    logic       p_io_in;
    logic       s_mem_cmd;
    logic       p_mem_cmd;
    logic       s_io_cmd;
    logic       p_io_cmd;

    assign s_bus      = sec_addr_i.addr[`ADDR_BUS_LSB +: 8];
    assign s_in_range = (s_bus >= cfg_i.sec_bus) && (s_bus <= cfg_i.sub_bus);
    assign s_type1    = sec_addr_i.addr[1:0] == `CFG_TYPE1;
    assign s_spc_req  = s_type1
                     && sec_addr_i.addr[`ADDR_DEV_LSB +: 5] == `SPC_DEVICE
                     && sec_addr_i.addr[`ADDR_FUNC_LSB +: 3] == `SPC_FUNCTION;

    function automatic logic is_mem(input logic [3:0] c);
        is_mem = c == `CMD_MEM_READ || c == `CMD_MEM_WRITE
              || c == `CMD_MEM_RD_MULT || c == `CMD_MEM_RD_LINE
              || c == `CMD_MEM_WR_INV;
    endfunction : is_mem

    assign s_mem_cmd = is_mem(sec_addr_i.cmd);
    assign p_mem_cmd = is_mem(pri_addr_i.cmd);
    assign s_io_cmd  = sec_addr_i.cmd == `CMD_IO_READ
                    || sec_addr_i.cmd == `CMD_IO_WRITE;
    assign p_io_cmd  = pri_addr_i.cmd == `CMD_IO_READ
                    || pri_addr_i.cmd == `CMD_IO_WRITE;

    range_check #(.WIDTH(32)) u_s_mem (.value_i(sec_addr_i.addr),
        .base_i(cfg_i.mem_base), .limit_i(cfg_i.mem_limit),
        .inside_o(s_mem_in));
    range_check #(.WIDTH(32)) u_s_io (.value_i(sec_addr_i.addr),
        .base_i(cfg_i.io_base), .limit_i(cfg_i.io_limit),
        .inside_o(s_io_in));
    range_check #(.WIDTH(32)) u_p_mem (.value_i(pri_addr_i.addr),
        .base_i(cfg_i.mem_base), .limit_i(cfg_i.mem_limit),
        .inside_o(p_mem_in));
    range_check #(.WIDTH(32)) u_p_io (.value_i(pri_addr_i.addr),
        .base_i(cfg_i.io_base), .limit_i(cfg_i.io_limit),
        .inside_o(p_io_in));

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.sdec.valid = 1'b0;
        st_nxt.s_sel   = 1'b0;
        st_nxt.s_retry = 1'b0;
        st_nxt.p_sel   = 1'b0;
        st_nxt.p_retry = 1'b0;
        // a new address phase is only seen when frame opens a cycle
        if (sec_addr_i.valid)
        begin
            st_nxt.sdec.valid        = 1'b1;
            st_nxt.sdec.act          = ACT_IGNORE;
            st_nxt.sdec.dac          = st_r.dac_pend;
            st_nxt.sdec.upstream_cfg = 1'b0;
            st_nxt.sdec.bus          = s_bus;
            st_nxt.dac_pend          = 1'b0;
            unique case (sec_addr_i.cmd)
                `CMD_DUAL_ADDR:
                begin
                    st_nxt.dac_pend   = 1'b1;
                    st_nxt.sdec.valid = 1'b0;
                end
                `CMD_IO_READ, `CMD_IO_WRITE:
                    // inside the downstream window the target is local
                    if (!s_io_in)
                        st_nxt.sdec.act = ACT_CLAIM;
                `CMD_MEM_READ, `CMD_MEM_WRITE, `CMD_MEM_RD_MULT,
                `CMD_MEM_RD_LINE, `CMD_MEM_WR_INV:
                    if (!s_mem_in || st_r.dac_pend)
                        st_nxt.sdec.act = ACT_CLAIM;
                `CMD_CFG_WRITE:
                    if (s_spc_req)
                    begin
                        if (s_bus == cfg_i.pri_bus)
                            st_nxt.sdec.act = ACT_CLAIM_SPC;
                        else if (!s_in_range)
                        begin
                            st_nxt.sdec.act          = ACT_CLAIM;
                            st_nxt.sdec.upstream_cfg = 1'b1;
                        end
                    end // else
                default:
                    st_nxt.sdec.act = ACT_IGNORE;
            endcase
            if (st_nxt.sdec.valid && st_nxt.sdec.act != ACT_IGNORE)
            begin
                st_nxt.s_sel = 1'b1;
                if (!postable_i || st_nxt.sdec.act == ACT_CLAIM_SPC)
                    st_nxt.s_retry = 1'b1;
            end
        end
        if (pri_addr_i.valid && !pri_other_devsel_i)
        begin
            if ((p_mem_cmd && p_mem_in) || (p_io_cmd && p_io_in))
            begin
                st_nxt.p_sel = 1'b1;
                if (st_r.st == ST_WAIT && pri_addr_i == st_r.held)
                    st_nxt.st = ST_IDLE;
                else if (!postable_i)
                begin
                    st_nxt.p_retry = 1'b1;
                    if (st_r.st == ST_IDLE)
                    begin
                        st_nxt.st   = ST_FWD;
                        st_nxt.held = pri_addr_i;
                    end
                end
            end // else silent
        end
        unique case (st_r.st)
            ST_FWD:  if (fwd_done_i) st_nxt.st = ST_WAIT;
            ST_IDLE, ST_WAIT: ;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            st_r <= '0;
            st_r.sdec.act <= ACT_IGNORE;
            st_r.st <= ST_IDLE;
        end
        else
            st_r <= st_nxt;
    end

    assign sec_dec_o                 = st_r.sdec;
    assign sec_device_select_n_o     = ~st_r.s_sel;
    assign sec_retry_o               = st_r.s_retry;
    assign primary_device_select_n_o = ~st_r.p_sel;
    assign pri_retry_o               = st_r.p_retry;
    assign fwd_req_o                 = st_r.st == ST_FWD;

    a_int_ack_ignored: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        sec_addr_i.valid && sec_addr_i.cmd == `CMD_INT_ACK
        |=> sec_device_select_n_o)
        else $error("interrupt acknowledge claimed");
    a_special_unclaimed: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        sec_addr_i.valid && sec_addr_i.cmd == `CMD_SPECIAL
        |=> sec_dec_o.act == ACT_IGNORE && sec_device_select_n_o)
        else $error("special cycle claimed");
    a_io_claim_up: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        sec_addr_i.valid && s_io_cmd && !s_io_in
        |=> sec_dec_o.act == ACT_CLAIM && !sec_device_select_n_o)
        else $error("upstream io not claimed");
    a_mem_claim_up: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        sec_addr_i.valid && s_mem_cmd && !s_mem_in
        |=> sec_dec_o.act == ACT_CLAIM && !sec_device_select_n_o)
        else $error("upstream memory not claimed");
    a_cfg_read_ignored: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        sec_addr_i.valid && sec_addr_i.cmd == `CMD_CFG_READ
        |=> sec_device_select_n_o && sec_dec_o.act == ACT_IGNORE)
        else $error("config read claimed");
    a_type1_plain: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        sec_addr_i.valid && sec_addr_i.cmd == `CMD_CFG_WRITE && !s_spc_req
        |=> sec_device_select_n_o)
        else $error("plain config write claimed");
    a_spc_primary: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        sec_addr_i.valid && sec_addr_i.cmd == `CMD_CFG_WRITE && s_spc_req
        && s_bus == cfg_i.pri_bus && !st_r.dac_pend
        |=> sec_dec_o.act == ACT_CLAIM_SPC && !sec_device_select_n_o)
        else $error("special request not reissued");
    a_spc_forward: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        sec_addr_i.valid && sec_addr_i.cmd == `CMD_CFG_WRITE && s_spc_req
        && s_bus != cfg_i.pri_bus && !s_in_range
        |=> sec_dec_o.act == ACT_CLAIM && sec_dec_o.upstream_cfg)
        else $error("foreign special request not forwarded");
    a_spc_in_range: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        sec_addr_i.valid && sec_addr_i.cmd == `CMD_CFG_WRITE && s_spc_req
        && s_bus != cfg_i.pri_bus && s_in_range
        |=> sec_device_select_n_o)
        else $error("special request into range claimed");
    a_dac_claim: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        sec_addr_i.valid && s_mem_cmd && st_r.dac_pend
        |=> sec_dec_o.dac && sec_dec_o.act == ACT_CLAIM)
        else $error("dual address memory cycle not claimed");
    a_sec_local_silent: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        sec_addr_i.valid && s_mem_cmd && s_mem_in && !st_r.dac_pend
        |=> sec_device_select_n_o)
        else $error("local secondary target claimed");
    a_retry_needs_sel: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        sec_retry_o |-> !sec_device_select_n_o)
        else $error("retry without select");

    sequence fwd_finish;
        fwd_req_o && fwd_done_i;
    endsequence

    sequence repeat_seen;
        st_r.st == ST_WAIT && pri_addr_i.valid && !pri_other_devsel_i
        && pri_addr_i == st_r.held;
    endsequence

    a_fwd_finish: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        fwd_finish |=> !fwd_req_o)
        else $error("forward request held after completion");
    a_wait_repeat: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        repeat_seen |=> !primary_device_select_n_o && !pri_retry_o)
        else $error("repeated cycle not completed");
    a_pri_other_silent: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        pri_addr_i.valid && pri_other_devsel_i
        |=> primary_device_select_n_o)
        else $error("primary select over other target");
    a_pri_claim_window: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        pri_addr_i.valid && !pri_other_devsel_i && p_mem_cmd && p_mem_in
        |=> !primary_device_select_n_o)
        else $error("primary window cycle not claimed");
    a_pri_no_target: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        pri_addr_i.valid && p_mem_cmd && !p_mem_in
        |=> primary_device_select_n_o)
        else $error("primary claimed outside window");

endmodule : claim_decode

`default_nettype wire

// *** rtl/claim_decode_cfg.svh ***
/*
 * Constants for the bridge claim decoder: command codes, special cycle
 * request fields and address field offsets.
 * Assumes inclusion by bare name from the decoder and the bench modules.
 */
`ifndef CLAIM_DECODE_CFG_SVH
`define CLAIM_DECODE_CFG_SVH

`define CMD_INT_ACK      4'h0
`define CMD_SPECIAL      4'h1
`define CMD_IO_READ      4'h2
`define CMD_IO_WRITE     4'h3
`define CMD_MEM_READ     4'h6
`define CMD_MEM_WRITE    4'h7
`define CMD_CFG_READ     4'hA
`define CMD_CFG_WRITE    4'hB
`define CMD_MEM_RD_MULT  4'hC
`define CMD_DUAL_ADDR    4'hD
`define CMD_MEM_RD_LINE  4'hE
`define CMD_MEM_WR_INV   4'hF

`define SPC_DEVICE       5'h1F
`define SPC_FUNCTION     3'h7
`define CFG_TYPE1        2'h1

`define ADDR_DEV_LSB     11
`define ADDR_FUNC_LSB    8
`define ADDR_BUS_LSB     16

`endif

// *** rtl/claim_decode_pkg.sv ***
/*
 * Types shared by the claim decoder.
 * Assumes claim_decode_cfg.svh is on the include path.
 */
package claim_decode_pkg;

    typedef enum logic [2:0]
    {
        ACT_IGNORE    = 3'h1,
        ACT_CLAIM     = 3'h2,
        ACT_CLAIM_SPC = 3'h4
    } action_t;

    typedef struct packed
    {
        logic        valid;
        logic [3:0]  cmd;
        logic [31:0] addr;
    } addr_phase_t;

    typedef struct packed
    {
        logic [7:0]  pri_bus;
        logic [7:0]  sec_bus;
        logic [7:0]  sub_bus;
        logic [31:0] mem_base;
        logic [31:0] mem_limit;
        logic [31:0] io_base;
        logic [31:0] io_limit;
    } window_cfg_t;

    typedef struct packed
    {
        logic        valid;
        action_t     act;
        logic        dac;
        logic        upstream_cfg;
        logic [7:0]  bus;
    } decision_t;

endpackage : claim_decode_pkg

// *** rtl/range_check.sv ***
/*
 * Address range comparator for the forwarding windows.
 * Assumes base and limit are inclusive; empty when base > limit.
 */
`timescale 1ns/100ps
`default_nettype none

module range_check
#(
    parameter int WIDTH = 32
)
(
    input  wire logic [WIDTH-1:0] value_i,
    input  wire logic [WIDTH-1:0] base_i,
    input  wire logic [WIDTH-1:0] limit_i,
    output logic                  inside_o
);

    assign inside_o = (value_i >= base_i) && (value_i <= limit_i);

endmodule : range_check

`default_nettype wire

// *** verification/claim_decode_bench.sv ***
/*
 * Self-checking bench for the claim decoder with a forwarding target model.
 * Assumes one address phase per task, two when a dual address phase leads; outputs answer one edge later.
 */
`timescale 1ns/100ps
`default_nettype none
`include "claim_decode_cfg.svh"

module claim_decode_bench
    import claim_decode_pkg::*;
;

    localparam logic [31:0] UP_ADDR = 32'h8000_0000;
    localparam logic [31:0] MEM_WIN = 32'h4000_0100;
    localparam logic [31:0] IO_WIN  = 32'h0000_1800;
    localparam logic [3:0]  PRI_WR  = `CMD_MEM_WRITE;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    window_cfg_t cfg;
    addr_phase_t sec_addr = '0;
    addr_phase_t pri_addr = '0;
    logic        other_sel = 1'b0;
    logic        postable = 1'b1;
    logic        fwd_done;
    decision_t   dec;
    logic        sec_sel_n, sec_retry, pri_sel_n, pri_retry, fwd_req;
    int          mismatches = 0;
    int          n_tests = 0;

    assign cfg = '{8'h01, 8'h02, 8'h05, 32'h4000_0000, 32'h4FFF_FFFF,
                   32'h0000_1000, 32'h0000_1FFF};

    always #2 clk_i = ~clk_i;

    claim_decode u_claim_decode (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .cfg_i(cfg), .sec_addr_i(sec_addr), .pri_addr_i(pri_addr),
        .pri_other_devsel_i(other_sel), .postable_i(postable),
        .fwd_done_i(fwd_done), .sec_dec_o(dec),
        .sec_device_select_n_o(sec_sel_n), .sec_retry_o(sec_retry),
        .primary_device_select_n_o(pri_sel_n), .pri_retry_o(pri_retry),
        .fwd_req_o(fwd_req));

    fwd_target_model #(.LAT(3)) u_fwd_target_model (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .fwd_req_i(fwd_req), .fwd_done_o(fwd_done));

    task automatic chk_bit(input logic got, input logic exp, input string m);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask : chk_bit

    task automatic chk_act(input action_t got, input action_t exp);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %0t act %0h", $time, got);
        end
    endtask : chk_act

    // a dual address phase goes back to back with the phase it qualifies
    task automatic sec_cyc(input logic [3:0] c, input logic [31:0] a,
                           input logic p, input logic dac, input action_t x,
                           input logic up);
        @(posedge clk_i);
        postable <= p;
        if (dac)
        begin
            sec_addr <= '{1'b1, `CMD_DUAL_ADDR, 32'h0000_0001};
            @(posedge clk_i);
        end
        sec_addr <= '{1'b1, c, a};
        @(posedge clk_i);
        sec_addr.valid <= 1'b0;
        #1;
        chk_bit(dec.valid, 1'b1, "valid");
        chk_act(dec.act, x);
        chk_bit(sec_sel_n, x == ACT_IGNORE, "select");
        chk_bit(sec_retry, x != ACT_IGNORE && (!p || x == ACT_CLAIM_SPC),
                "retry");
        chk_bit(dec.upstream_cfg, up, "upstream");
        chk_bit(dec.dac, dac, "dac");
        chk_bit(dec.bus === a[`ADDR_BUS_LSB +: 8], 1'b1, "bus");
    endtask : sec_cyc

    task automatic pri_cyc(input logic [3:0] c, input logic [31:0] a,
                           input logic o, input logic p,
                           input logic sel, input logic rty);
        @(posedge clk_i);
        pri_addr <= '{1'b1, c, a};
        other_sel <= o;
        postable <= p;
        @(posedge clk_i);
        pri_addr.valid <= 1'b0;
        other_sel <= 1'b0;
        #1;
        chk_bit(pri_sel_n, !sel, "pri select");
        chk_bit(pri_retry, rty, "pri retry");
        chk_bit(fwd_req, rty, "fwd req");
    endtask : pri_cyc

    function automatic logic [31:0] spc(input logic [7:0] bus, input logic s);
        return {8'h00, bus, s ? `SPC_DEVICE : 5'h03,
                s ? `SPC_FUNCTION : 3'h0, 6'h00, `CFG_TYPE1};
    endfunction : spc

    task automatic plain_cyc(input logic [3:0] c, input logic [31:0] a,
                             input logic p, input action_t x);
        sec_cyc(c, a, p, 1'b0, x, 1'b0);
    endtask : plain_cyc

    task automatic spc_cyc(input logic [7:0] bus, input logic s,
                           input action_t x, input logic up);
        sec_cyc(`CMD_CFG_WRITE, spc(bus, s), 1'b1, 1'b0, x, up);
    endtask : spc_cyc

    task automatic all_cmds;
        action_t x;
        for (int c = 0; c < 16; c++)
        begin
            if (c == 13)
                continue;
            x = (c inside {2, 3, 6, 7, 12, 14, 15}) ? ACT_CLAIM : ACT_IGNORE;
            plain_cyc(c[3:0], UP_ADDR, 1'b1, x);
        end
    endtask : all_cmds

    task automatic special_reqs;
        spc_cyc(8'h01, 1'b1, ACT_CLAIM_SPC, 1'b0);
        spc_cyc(8'h05, 1'b1, ACT_IGNORE, 1'b0);
        spc_cyc(8'h02, 1'b1, ACT_IGNORE, 1'b0);
        spc_cyc(8'h09, 1'b1, ACT_CLAIM, 1'b1);
        spc_cyc(8'h01, 1'b0, ACT_IGNORE, 1'b0);
    endtask : special_reqs

    // window addresses mean a local target here, so the bridge stays quiet unless a dual address phase precedes a memory command
    task automatic sec_paths;
        plain_cyc(`CMD_MEM_READ, MEM_WIN, 1'b1, ACT_IGNORE);
        plain_cyc(`CMD_IO_READ, IO_WIN, 1'b1, ACT_IGNORE);
        plain_cyc(`CMD_MEM_RD_MULT, MEM_WIN, 1'b1, ACT_IGNORE);
        plain_cyc(`CMD_MEM_WRITE, UP_ADDR, 1'b0, ACT_CLAIM);
        sec_cyc(`CMD_MEM_READ, MEM_WIN, 1'b1, 1'b1, ACT_CLAIM, 1'b0);
    endtask : sec_paths

    task automatic pri_paths;
        pri_cyc(PRI_WR, UP_ADDR, 1'b0, 1'b0, 1'b0, 1'b0);
        pri_cyc(PRI_WR, MEM_WIN, 1'b1, 1'b0, 1'b0, 1'b0);
        pri_cyc(`CMD_IO_WRITE, IO_WIN, 1'b0, 1'b1, 1'b1, 1'b0);
        pri_cyc(PRI_WR, MEM_WIN, 1'b0, 1'b0, 1'b1, 1'b1);
        for (int i = 0; i < 50 && fwd_req !== 1'b0; i++)
        begin
            @(posedge clk_i);
            #1;
        end
        chk_bit(fwd_req, 1'b0, "fwd end");
        pri_cyc(PRI_WR, MEM_WIN, 1'b0, 1'b0, 1'b1, 1'b0);
    endtask : pri_paths

    task automatic complete_run;
        $display("mismatches %0d n_tests %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run

    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1;
        chk_bit(sec_sel_n, 1'b1, "reset select");
        chk_bit(pri_sel_n, 1'b1, "reset pri select");
        chk_bit(dec.valid, 1'b0, "reset valid");
        chk_bit(fwd_req, 1'b0, "reset fwd");
        all_cmds();
        special_reqs();
        sec_paths();
        pri_paths();
        complete_run();
    end

    // the sequence needs about seventy-five cycles; over twenty times that is a hang
    initial
    begin
        repeat (2000) @(posedge clk_i);
        mismatches++;
        complete_run();
    end
endmodule : claim_decode_bench

`default_nettype wire

// *** verification/fwd_target_model.sv ***
/*
 * Behavioural model of the target port that completes a forwarded cycle.
 * Assumes fwd_req_i is a registered level on clk_i that drops after done.
 */
`timescale 1ns/100ps
`default_nettype none

module fwd_target_model
#(
    parameter int LAT = 3
)
(
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic fwd_req_i,
    output logic      fwd_done_o
);
    int   cnt_r;
    logic done_r;

    // one completion per request; rearms only once the level has dropped
    always_ff @(posedge clk_i)
    begin
        fwd_done_o <= 1'b0;
        if (!rst_n_i || !fwd_req_i)
        begin
            cnt_r  <= 0;
            done_r <= 1'b0;
        end
        else if (!done_r && cnt_r == LAT)
        begin
            fwd_done_o <= 1'b1;
            done_r     <= 1'b1;
        end
        else
            cnt_r <= cnt_r + 1;
    end
endmodule : fwd_target_model

`default_nettype wire
